// ### dv/rbc_checker.sv
// Port assertions for the reset and brown-out control.
`timescale 1ns/1ps
`include "rbc_map.svh"

module rbc_checker
	import rbc_pkg::*;
(
	// Clock, reset and bus
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        ack_o,
	// Configuration and monitors
	input wire rbc_config_s cfg_i,
	input wire rbc_analog_s analog_i,
	input wire logic        reset_pin_i,
	// Results
	input wire logic        reset_pin_o,
	input wire logic        reset_pin_oe_o,
	input wire logic        reset_pin_pullup_o,
	input wire logic        brownout_enable_o,
	input wire logic        brownout_level_low_o,
	input wire logic        band_gap_force_o,
	input wire logic        low_power_brownout_en_o,
	input wire logic        brownout_reset_o,
	input wire logic        brownout_flag_o,
	input wire logic        internal_reset_o
);
	localparam int FLT = `RBC_FILTER_CYC;
	localparam int PFLT = `RBC_PIN_FILTER_CYC + 5;
	int   low_q;
	int   dip_q;
	logic pin_en;
	assign pin_en = cfg_i.external_reset_pin_enable | cfg_i.low_voltage_program_enable;
	// Run lengths of the raw requests, so filter figures can be judged.
	always_ff @(posedge clk_i) begin
		low_q <= (pin_en && !reset_pin_i) ? low_q + 1 : 0;
		dip_q <= (analog_i.brownout_below || analog_i.low_power_below) ? dip_q + 1 : 0;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence take_s;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence pulse_s;
		ack_o ##1 !ack_o;
	endsequence
	bus_ack_a: assert property (take_s |=> pulse_s) else $error("ack not one pulse");
	pin_input_a: assert property (!reset_pin_oe_o && !reset_pin_o) else $error("pin driven");
	pin_pullup_a: assert property (pin_en |=> reset_pin_pullup_o) else $error("pull-up off");
	pin_hold_a: assert property (low_q > PFLT |-> internal_reset_o) else $error("pin low ignored");
	dip_filter_a: assert property ($rose(brownout_reset_o) |-> dip_q >= FLT) else $error("short dip");
	lp_enable_a: assert property (1 |=> low_power_brownout_en_o == !$past(cfg_i.low_power_brownout_n))
		else $error("low-power enable wrong");
	level_sel_a: assert property (1 |=> brownout_level_low_o == $past(cfg_i.brownout_level_sel))
		else $error("level wrong");
	band_gap_a: assert property (band_gap_force_o |->
		$past(cfg_i.brownout_mode_sel) inside {2'b10, 2'b01})
		else $error("band gap forced");
	mode_off_a: assert property (cfg_i.brownout_mode_sel == RBC_MODE_OFF |=> !brownout_enable_o)
		else $error("detector on");
	mode_on_a: assert property (cfg_i.brownout_mode_sel == RBC_MODE_ALWAYS |=> brownout_enable_o)
		else $error("detector off");
	flag_set_a: assert property (brownout_reset_o |-> ##[0:2] brownout_flag_o) else $error("no flag");
	reset_join_a: assert property (brownout_reset_o |-> ##[0:2] internal_reset_o) else $error("no reset");
endmodule

bind rbc_top rbc_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
	.cfg_i(cfg_i), .analog_i(analog_i), .reset_pin_i(reset_pin_i), .reset_pin_o(reset_pin_o),
	.reset_pin_oe_o(reset_pin_oe_o), .reset_pin_pullup_o(reset_pin_pullup_o), .brownout_enable_o(brownout_enable_o),
	.brownout_level_low_o(brownout_level_low_o), .band_gap_force_o(band_gap_force_o),
	.low_power_brownout_en_o(low_power_brownout_en_o), .brownout_reset_o(brownout_reset_o),
	.brownout_flag_o(brownout_flag_o), .internal_reset_o(internal_reset_o));

// ### dv/rbc_far_model.sv
// Supply monitors and reset pin as the block sees them.
`timescale 1ns/1ps

module rbc_far_model
	import rbc_pkg::*;
(
	// Clock and bench commands
	input  wire logic   clk_i,
	input  wire logic   por_i,
	input  wire logic   below_i,
	input  wire logic   lp_below_i,
	input  wire logic   pin_low_i,
	// From the block
	input  wire logic   enable_i,
	input  wire logic   pullup_i,
	// To the block
	output rbc_analog_s analog_o,
	output logic        pin_o
);
	int   rdy_q = 0;
	logic flt_q = 1'b0;
	// The comparator needs time to settle, so ready lags the enable.
	always_ff @(posedge clk_i) begin
		rdy_q <= enable_i ? ((rdy_q < 8) ? rdy_q + 1 : 8) : 0;
		flt_q <= ~flt_q;
	end
	assign analog_o = {por_i, below_i, rdy_q == 8, lp_below_i};
	// A floating pin without pull-up reads as noise, never as a held level.
	assign pin_o = pin_low_i ? 1'b0 : (pullup_i ? 1'b1 : flt_q);
endmodule

// ### dv/testbench.sv
// Self-checking bench for the reset and brown-out control.
`timescale 1ns/1ps
`include "rbc_map.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] %s exp %h got %h", nm, e, g); end end

module testbench
	import rbc_pkg::*;
;
	localparam int DLY = 400;
	localparam logic [3:0] CTL = `RBC_BROWNOUT_CONTROL_ADDR;
	logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, sleep = 0, pup_sw = 0;
	logic        por = 1, below = 0, lpb = 0, pin_low = 0;
	logic        ack_o, pin, pin_oe, pin_o, pup, gpio, bo_en, lvl, bgf, lp_en, bo_rst, flag, irst;
	logic [3:0]  adr = '0, sel = 4'hf;
	logic [31:0] dat = '0, rd, dat_o;
	rbc_config_s cfg = '{RBC_MODE_ALWAYS, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
	rbc_analog_s ana;
	int          n_mismatch = 0, samples_checked = 0, n, sw = 1, fs = 0;

	initial begin
		forever #12.5 clk_i = ~clk_i;
	end
	rbc_top #(.POWER_UP_DELAY_CYC(DLY), .SLOW_DIV(4)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
		.cfg_i(cfg), .sleep_i(sleep), .pin_pullup_sw_i(pup_sw), .analog_i(ana), .reset_pin_i(pin),
		.reset_pin_o(pin_o), .reset_pin_oe_o(pin_oe), .reset_pin_pullup_o(pup), .pin_gpio_o(gpio),
		.brownout_enable_o(bo_en), .brownout_level_low_o(lvl), .band_gap_force_o(bgf),
		.low_power_brownout_en_o(lp_en), .brownout_reset_o(bo_rst), .brownout_flag_o(flag),
		.internal_reset_o(irst));
	rbc_far_model far_u (.clk_i(clk_i), .por_i(por), .below_i(below), .lp_below_i(lpb), .pin_low_i(pin_low),
		.enable_i(bo_en), .pullup_i(pup), .analog_o(ana), .pin_o(pin));

	// ----------------------------------------------------------------------------
	// Reference model and drivers
	// ----------------------------------------------------------------------------
	function automatic logic en_exp(input logic [1:0] m, input logic s, input logic sl);
		return m == 2'b11 || (m == 2'b10 && !sl) || (m == 2'b01 && s);
	endfunction
	task automatic conclude();
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		i = 0;
		do begin
			@(posedge clk_i);
			i++;
		end while (ack_o !== 1'b1 && i < 20);
		rd = dat_o;
		if (ack_o !== 1'b1) begin
			n_mismatch++;
			conclude();
		end
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// A wait that never ends would hide a stuck reset, so it is bounded.
	task automatic wait_irst(output int c);
		c = 0;
		while (irst !== 1'b0 && c < 2000) begin
			@(posedge clk_i);
			c++;
		end
		if (irst !== 1'b0) begin
			n_mismatch++;
			conclude();
		end
	endtask

	// ----------------------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------------------
	initial begin
		void'($urandom(32'hbc9a));
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (20) @(posedge clk_i);
		`CHK("por_hold", 1'b1, irst)
		por <= 1'b0;
		wait_irst(n);
		`CHK("delay_len", 1'b1, n >= DLY && n <= DLY + 40)
		wb(0, CTL, '0);
		`CHK("ctl_reset", 32'h0000_0081, rd)
		wb(0, 4'h8, 32'hffff_ffff);
		`CHK("unmapped", 32'h0000_0000, rd)
		for (int k = 0; k < 4; k++) begin
			n = $urandom;
			sel <= k[0] ? 4'h1 : 4'h0;
			wb(1, CTL, n);
			if (k[0]) begin
				sw = n[7];
				fs = n[6];
			end
			wb(0, CTL, '0);
			`CHK("ctl_rw", {sw[0], fs[0], 6'b00_0001}, rd[7:0])
		end
		sel <= 4'hf;
		for (int k = 0; k < 16; k++) begin
			cfg.brownout_mode_sel <= rbc_mode_e'(k[3:2]);
			cfg.brownout_level_sel <= k[0];
			sleep <= k[0];
			wb(1, CTL, {k[1], 7'h40});
			repeat (12) @(posedge clk_i);
			`CHK("det_on", en_exp(k[3:2], k[1], k[0]), bo_en)
			`CHK("bg_force", k[3] ^ k[2], bgf)
			`CHK("level", k[0], lvl)
			wb(0, CTL, '0);
			`CHK("ready_bit", en_exp(k[3:2], k[1], k[0]), rd[0])
		end
		sleep <= 1'b0;
		wb(1, CTL, 32'h0000_0080);
		repeat (12) @(posedge clk_i);
		below <= 1'b1;
		repeat (20) @(posedge clk_i);
		below <= 1'b0;
		repeat (10) @(posedge clk_i);
		`CHK("short_dip", 2'b00, {bo_rst, flag})
		below <= 1'b1;
		repeat (60) @(posedge clk_i);
		`CHK("long_dip", 3'b111, {bo_rst, flag, irst})
		wb(0, `RBC_STATUS_ADDR, '0);
		`CHK("status", 32'h0000_0037, rd)
		below <= 1'b0;
		wait_irst(n);
		`CHK("bor_delay", 1'b1, n >= DLY && n <= DLY + 80)
		for (int k = 0; k < 2; k++) begin
			cfg.brownout_mode_sel <= RBC_MODE_OFF;
			cfg.low_power_brownout_n <= k[0];
			wb(1, CTL, 32'h0000_0080);
			lpb <= 1'b1;
			repeat (60) @(posedge clk_i);
			`CHK("lp_trip", {3{~k[0]}}, {lp_en, bo_rst, flag})
			lpb <= 1'b0;
			wait_irst(n);
		end
		cfg.brownout_mode_sel <= RBC_MODE_NO_SLEEP;
		sleep <= 1'b1;
		repeat (12) @(posedge clk_i);
		`CHK("sleep_run", 2'b00, {bo_en, irst})
		sleep <= 1'b0;
		repeat (3) @(posedge clk_i);
		`CHK("wake_wait", 1'b1, irst)
		wait_irst(n);
		cfg.brownout_mode_sel <= RBC_MODE_OFF;
		cfg.power_up_delay_enable_n <= 1'b1;
		for (int k = 0; k < 5; k++) begin
			cfg.external_reset_pin_enable <= k[0];
			cfg.low_voltage_program_enable <= k[1];
			pup_sw <= k[2];
			pin_low <= 1'b1;
			repeat (5) @(posedge clk_i);
			pin_low <= 1'b0;
			repeat (30) @(posedge clk_i);
			`CHK("pin_pulse", 1'b0, irst)
			`CHK("pullup", k[1:0] != 0 || k[2], pup)
			pin_low <= 1'b1;
			repeat (40) @(posedge clk_i);
			`CHK("pin_hold", k[1:0] != 0, irst)
			`CHK("pin_gpio", 1'b0, gpio)
			`CHK("pin_undriven", 2'b00, {pin_oe, pin_o})
			pin_low <= 1'b0;
			wait_irst(n);
		end
		conclude();
	end
endmodule

// ### shared/rbc_map.svh
// Register map, field positions, reset values and timing counts of the reset and brown-out control.
`ifndef RBC_MAP_SVH
`define RBC_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define RBC_BROWNOUT_CONTROL_ADDR 4'h0
`define RBC_STATUS_ADDR           4'h4
`define RBC_ADDR_W                4

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define RBC_SW_BROWNOUT_ENABLE_BIT 7
`define RBC_BROWNOUT_FAST_START_BIT 6
`define RBC_BROWNOUT_READY_BIT     0
`define RBC_SW_BROWNOUT_ENABLE_RST 1'b1
`define RBC_BROWNOUT_FAST_START_RST 1'b0
`define RBC_ST_RESET_ACTIVE_BIT    0
`define RBC_ST_DELAY_RUN_BIT       1
`define RBC_ST_BROWNOUT_FLAG_BIT   2
`define RBC_ST_PIN_RESET_BIT       3
`define RBC_ST_BROWNOUT_ON_BIT     4
`define RBC_ST_PIN_LEVEL_BIT       5

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define RBC_CLK_HZ            40000000
`define RBC_POWER_UP_DELAY_US 64000
`define RBC_POWER_UP_DELAY_CYC ((`RBC_CLK_HZ / 1000) * (`RBC_POWER_UP_DELAY_US / 1000))
`define RBC_FILTER_TIME_NS    1000
`define RBC_FILTER_CYC        ((`RBC_FILTER_TIME_NS * (`RBC_CLK_HZ / 1000000) + 999) / 1000)
`define RBC_PIN_FILTER_NS     500
`define RBC_PIN_FILTER_CYC    ((`RBC_PIN_FILTER_NS * (`RBC_CLK_HZ / 1000000) + 999) / 1000)
`define RBC_SLOW_DIV          40

`endif

// ### shared/rbc_pkg.sv
// Types shared by the reset and brown-out control.
package rbc_pkg;

	typedef enum logic [1:0] {
		RBC_MODE_OFF      = 2'b00,
		RBC_MODE_SOFTWARE = 2'b01,
		RBC_MODE_NO_SLEEP = 2'b10,
		RBC_MODE_ALWAYS   = 2'b11
	} rbc_mode_e;

	typedef struct packed {
		rbc_mode_e  brownout_mode_sel;
		logic       brownout_level_sel;
		logic       power_up_delay_enable_n;
		logic       low_power_brownout_n;
		logic       external_reset_pin_enable;
		logic       low_voltage_program_enable;
	} rbc_config_s;

	typedef struct packed {
		logic power_on;
		logic brownout_below;
		logic brownout_ready;
		logic low_power_below;
	} rbc_analog_s;

endpackage

// ### src/rbc_delay.sv
// Power-up delay counter advanced by a slow tick.
`timescale 1ns/1ps

module rbc_delay
	import rbc_pkg::*;
#(
	parameter int unsigned TICKS = 1600
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Control
	input  wire logic restart_i,
	input  wire logic tick_i,
	output logic      running_o
);

	localparam int unsigned CW = $clog2(TICKS + 1);

	logic [CW-1:0] cnt_q;
	wire           done = (cnt_q == CW'(TICKS));

	always_ff @(posedge clk_i) begin
		if (rst_i || restart_i) begin
			cnt_q <= '0;
		end else if (tick_i && !done) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	assign running_o = !done;

endmodule

// ### src/rbc_filter.sv
// Persistence filter: output follows input only after it has held for a number of cycles.
`timescale 1ns/1ps

module rbc_filter
	import rbc_pkg::*;
#(
	parameter int unsigned CYCLES = 40
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Data
	input  wire logic in_i,
	output logic      out_o
);

	localparam int unsigned CW = $clog2(CYCLES + 1);

	logic [CW-1:0] cnt_q;
	logic          out_q;
	wire           differs = (in_i != out_q);
	wire           done    = (cnt_q == CW'(CYCLES - 1));

	always_ff @(posedge clk_i) begin
		if (rst_i || !differs) begin
			cnt_q <= '0;
		end else if (!done) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_q <= 1'b0;
		end else if (differs && done) begin
			out_q <= in_i;
		end
	end

	assign out_o = out_q;

endmodule

// ### src/rbc_top.sv
// Reset and brown-out control with a classic Wishbone register slave.
`timescale 1ns/1ps
`include "rbc_map.svh"

module rbc_top
	import rbc_pkg::*;
#(
	parameter int unsigned POWER_UP_DELAY_CYC = `RBC_POWER_UP_DELAY_CYC,
	parameter int unsigned SLOW_DIV           = `RBC_SLOW_DIV
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [3:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]      dat_o,
	output logic             ack_o,
	// Configuration words and CPU state
	input  wire rbc_config_s cfg_i,
	input  wire logic        sleep_i,
	input  wire logic        pin_pullup_sw_i,
	// Analog monitors and reset pin
	input  wire rbc_analog_s analog_i,
	input  wire logic        reset_pin_i,
	output logic             reset_pin_o,
	output logic             reset_pin_oe_o,
	output logic             reset_pin_pullup_o,
	output logic             pin_gpio_o,
	// Analog controls
	output logic             brownout_enable_o,
	output logic             brownout_level_low_o,
	output logic             band_gap_force_o,
	output logic             low_power_brownout_en_o,
	// Results
	output logic             brownout_reset_o,
	output logic             brownout_flag_o,
	output logic             internal_reset_o
);

	// ------------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------------
	// Pin and monitor levels arrive from outside the clock domain and pass two flops first.
	localparam int unsigned NS = 5;
	logic [NS-1:0] sync1_q;
	logic [NS-1:0] sync2_q;
	wire  [NS-1:0] async_in = {reset_pin_i, analog_i.low_power_below, analog_i.brownout_ready,
		analog_i.brownout_below, analog_i.power_on};

	always_ff @(posedge clk_i) begin
		sync1_q <= async_in;
		sync2_q <= sync1_q;
	end

	wire por_s     = sync2_q[0];
	wire below_s   = sync2_q[1];
	wire ready_s   = sync2_q[2];
	wire lp_below_s = sync2_q[3];
	wire pin_s     = sync2_q[4];

	// ------------------------------------------------------------------------
	// Software register
	// ------------------------------------------------------------------------
	logic sw_en_q;
	logic fast_start_q;
	logic ack_q;
	logic [31:0] dat_q;
	wire  req        = cyc_i && stb_i && !ack_q;
	wire  hit_ctrl   = (adr_i == `RBC_BROWNOUT_CONTROL_ADDR);
	wire  hit_status = (adr_i == `RBC_STATUS_ADDR);
	// A write lands at the edge where the master sees ack, while it still holds the request.
	wire  wr_ctrl    = cyc_i && stb_i && ack_q && we_i && hit_ctrl && sel_i[0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sw_en_q <= `RBC_SW_BROWNOUT_ENABLE_RST;
		end else if (wr_ctrl) begin
			sw_en_q <= dat_i[`RBC_SW_BROWNOUT_ENABLE_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fast_start_q <= `RBC_BROWNOUT_FAST_START_RST;
		end else if (wr_ctrl) begin
			fast_start_q <= dat_i[`RBC_BROWNOUT_FAST_START_BIT];
		end
	end

	// ------------------------------------------------------------------------
	// Brown-out mode decode
	// ------------------------------------------------------------------------
	wire rbc_mode_e mode = cfg_i.brownout_mode_sel;
	wire mode_always = (mode == RBC_MODE_ALWAYS);
	wire mode_nosleep = (mode == RBC_MODE_NO_SLEEP);
	wire mode_sw     = (mode == RBC_MODE_SOFTWARE);
	// Detector on per mode; software mode is gated by the enable bit.
	wire bo_on = mode_always || (mode_nosleep && !sleep_i) || (mode_sw && sw_en_q);
	// Main detector protection only counts once the circuit reports ready.
	wire bo_active = bo_on && ready_s;
	// Start-up and wake from Sleep wait for ready in the two forced modes.
	// Sleep itself never becomes a reset, or the core would lose its state; only the wake waits.
	wire wait_ready = (mode_always || mode_nosleep) && !ready_s && !sleep_i;
	wire lp_en = !cfg_i.low_power_brownout_n;

	// ------------------------------------------------------------------------
	// Filters and the combined brown-out request
	// ------------------------------------------------------------------------
	logic bo_filt;
	logic lp_filt;
	logic pin_low_filt;

	// A dip must outlast the filter count; shorter dips never reach the reset.
	rbc_filter #(.CYCLES(`RBC_FILTER_CYC)) u_bo_filter (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.in_i  (bo_active && below_s),
		.out_o (bo_filt)
	);

	rbc_filter #(.CYCLES(`RBC_FILTER_CYC)) u_lp_filter (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.in_i  (lp_en && lp_below_s),
		.out_o (lp_filt)
	);

	// Pin reset is enabled by programming mode or the pin enable bit.
	wire pin_en = cfg_i.low_voltage_program_enable || cfg_i.external_reset_pin_enable;

	rbc_filter #(.CYCLES(`RBC_PIN_FILTER_CYC)) u_pin_filter (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.in_i  (pin_en && !pin_s),
		.out_o (pin_low_filt)
	);

	// Either detector's request counts as one brown-out.
	wire bo_req = bo_filt || lp_filt;

	// ------------------------------------------------------------------------
	// Power-up delay
	// ------------------------------------------------------------------------
	// The slow tick keeps the counter narrow at the cost of up to one tick of slack.
	localparam int unsigned TICKS = (POWER_UP_DELAY_CYC + SLOW_DIV - 1) / SLOW_DIV;
	localparam int unsigned DW = $clog2(SLOW_DIV + 1);
	logic [DW-1:0] div_q;
	wire  tick = (div_q == DW'(SLOW_DIV - 1));
	logic delay_run;

	always_ff @(posedge clk_i) begin
		if (rst_i || tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	// The counter is held at zero while power-on or brown-out is asserted, so the
	// delay only starts after both release.
	rbc_delay #(.TICKS(TICKS)) u_delay (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.restart_i (por_s || bo_req),
		.tick_i    (tick),
		.running_o (delay_run)
	);

	wire delay_hold = !cfg_i.power_up_delay_enable_n && delay_run;

	// ------------------------------------------------------------------------
	// Combined reset and sticky flag
	// ------------------------------------------------------------------------
	wire reset_d = por_s || bo_req || pin_low_filt || delay_hold || wait_ready;
	logic reset_q;
	logic flag_q;
	logic bo_req_q;
	wire  flag_clr = wr_ctrl && !dat_i[`RBC_ST_BROWNOUT_FLAG_BIT];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reset_q <= 1'b1;
		end else begin
			reset_q <= reset_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bo_req_q <= 1'b0;
		end else begin
			bo_req_q <= bo_req;
		end
	end

	// Either detector sets the one flag; a set wins over a clear.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_q <= 1'b0;
		end else if (bo_req) begin
			flag_q <= 1'b1;
		end else if (flag_clr) begin
			flag_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// Bus answer
	// ------------------------------------------------------------------------
	wire [31:0] ctrl_word = {24'h00_0000, sw_en_q, fast_start_q, 5'b0_0000, bo_active};
	wire [31:0] stat_word = {26'h000_0000, pin_s, bo_on, pin_low_filt, flag_q, delay_hold, reset_q};
	wire [31:0] rd_word = hit_ctrl ? ctrl_word : (hit_status ? stat_word : 32'h0000_0000);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req;
		end
	end

	// Read data stands only in the ack cycle, so a stale word is never seen.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_q <= 32'h0000_0000;
		end else begin
			dat_q <= (req && !we_i) ? rd_word : 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------------------
	logic bo_en_q;
	logic level_q;
	logic bg_q;
	logic lp_en_q;
	logic pullup_q;
	logic gpio_q;
	logic pin_drive_q;
	logic pin_oe_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bo_en_q <= 1'b0;
		end else begin
			bo_en_q <= bo_on;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			level_q <= 1'b0;
		end else begin
			level_q <= cfg_i.brownout_level_sel;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bg_q <= 1'b0;
		end else begin
			bg_q <= fast_start_q && (mode_nosleep || mode_sw);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lp_en_q <= 1'b0;
		end else begin
			lp_en_q <= lp_en;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pullup_q <= 1'b1;
		end else begin
			pullup_q <= pin_en || pin_pullup_sw_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gpio_q <= 1'b1;
		end else begin
			gpio_q <= pin_s;
		end
	end

	// The pin is an input only, so its drive and enable flops never leave zero.
	always_ff @(posedge clk_i) begin
		pin_drive_q <= 1'b0;
		pin_oe_q    <= 1'b0;
	end

	assign dat_o   = dat_q;
	assign ack_o   = ack_q;
	assign reset_pin_o    = pin_drive_q;
	assign reset_pin_oe_o = pin_oe_q;
	assign reset_pin_pullup_o = pullup_q;
	assign pin_gpio_o     = gpio_q;
	assign brownout_enable_o     = bo_en_q;
	assign brownout_level_low_o  = level_q;
	assign band_gap_force_o      = bg_q;
	assign low_power_brownout_en_o = lp_en_q;
	assign brownout_reset_o = bo_req_q;
	assign brownout_flag_o  = flag_q;
	assign internal_reset_o = reset_q;

endmodule
